/* File: design/bcrc_regs.sv */
// Register bank for channel 3 control and channel 0 output voltage
`timescale 1ns/1ps
module bcrc_regs
  import bcrc_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  bcrc_wr_t           wr_req,
  input  wire logic [7:0]    rd_addr,
  output logic [7:0]         rd_data_r,
  input  wire logic          enable_pin_a,
  input  wire logic          enable_pin_b,
  output bcrc_ch3_ctl_t      ch3_ctl_r,
  output logic [7:0]         ch0_voltage_code_r,
  output logic [1:0]         ch0_segment_r
);

  logic [7:0]    ch3_enable_and_mode_r;
  logic [7:0]    ch3_limit_and_slew_r;
  logic [7:0]    ch0_output_voltage_r;
  logic [7:0]    rd_data_nxt;
  logic [1:0]    seg_nxt;
  bcrc_ch3_ctl_t ctl_nxt;

  // Register writes; all bits store, reserved ones included
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ch3_enable_and_mode_r <= BCRC_RST_CH3_ENABLE_AND_MODE;
      ch3_limit_and_slew_r  <= BCRC_RST_CH3_LIMIT_AND_SLEW;
      ch0_output_voltage_r  <= BCRC_RST_CH0_OUTPUT_VOLTAGE;
    end else if (wr_req.wr_en) begin
      if (wr_req.addr == BCRC_ADDR_CH3_ENABLE_AND_MODE) begin
        ch3_enable_and_mode_r <= wr_req.wdata;
      end
      if (wr_req.addr == BCRC_ADDR_CH3_LIMIT_AND_SLEW) begin
        ch3_limit_and_slew_r <= wr_req.wdata;
      end
      if (wr_req.addr == BCRC_ADDR_CH0_OUTPUT_VOLTAGE) begin
        ch0_output_voltage_r <= wr_req.wdata;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (rd_addr)
      BCRC_ADDR_CH3_ENABLE_AND_MODE: rd_data_nxt = ch3_enable_and_mode_r;
      BCRC_ADDR_CH3_LIMIT_AND_SLEW:  rd_data_nxt = ch3_limit_and_slew_r;
      BCRC_ADDR_CH0_OUTPUT_VOLTAGE:  rd_data_nxt = ch0_output_voltage_r;
      default:                       rd_data_nxt = BCRC_READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data_r <= BCRC_READ_UNMAPPED;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Decode of channel 3 controls; reserved bits reach it but it leaves them unused
  bcrc_ch3_decode u_decode (
    .enable_mode  (ch3_enable_and_mode_r),
    .limit_slew   (ch3_limit_and_slew_r),
    .enable_pin_a (enable_pin_a),
    .enable_pin_b (enable_pin_b),
    .ctl          (ctl_nxt)
  );

  // Registered controls; one cycle of pin latency is negligible for a rail
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ch3_ctl_r <= '0;
    end else begin
      ch3_ctl_r <= ctl_nxt;
    end
  end

  // Segment index: 0 = 10 mV, 1 = 5 mV, 2 = 20 mV steps
  always_comb begin
    if (ch0_output_voltage_r < BCRC_VSEG1_FIRST) begin
      seg_nxt = 2'h0;
    end else if (ch0_output_voltage_r < BCRC_VSEG2_FIRST) begin
      seg_nxt = 2'h1;
    end else begin
      seg_nxt = 2'h2;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ch0_voltage_code_r <= BCRC_RST_CH0_OUTPUT_VOLTAGE;
      ch0_segment_r      <= 2'h1;
    end else begin
      ch0_voltage_code_r <= ch0_output_voltage_r;
      ch0_segment_r      <= seg_nxt;
    end
  end

  // Register writes seen on the port, the first step of every live update check
  sequence s_limit_write;
    wr_req.wr_en && wr_req.addr == BCRC_ADDR_CH3_LIMIT_AND_SLEW;
  endsequence

  sequence s_mode_write;
    wr_req.wr_en && wr_req.addr == BCRC_ADDR_CH3_ENABLE_AND_MODE;
  endsequence

  // Pin control off: the enable bit alone decides, one cycle later
  a_core_enable_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    !ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL]
    |=> ch3_ctl_r.core_on == $past(ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE]))
    else $error("core enable mismatch");

  // A cleared enable bit wins over any pin state
  a_core_bit_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE] |=> !ch3_ctl_r.core_on)
    else $error("core on with enable bit clear");

  a_pin_gate_and: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL] && !ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR]
     && !(ch3_enable_and_mode_r[BCRC_BIT_PIN_SELECT] ? enable_pin_b : enable_pin_a))
    |=> !ch3_ctl_r.core_on)
    else $error("core on with pin low");

  // Both pins high with the bit set must turn the core on
  a_pin_high_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE] && ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL]
     && !ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR] && enable_pin_a && enable_pin_b)
    |=> ch3_ctl_r.core_on)
    else $error("core off with pin high");

  a_pin_select_b: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE] && ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL]
     && ch3_enable_and_mode_r[BCRC_BIT_PIN_SELECT] && !ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR]
     && enable_pin_b && !enable_pin_a) |=> ch3_ctl_r.core_on)
    else $error("pin b select failed");

  // Pin A chosen: only pin A may decide the core state
  a_pin_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE] && ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL]
     && !ch3_enable_and_mode_r[BCRC_BIT_PIN_SELECT] && !ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR])
    |=> ch3_ctl_r.core_on == $past(enable_pin_a))
    else $error("pin a select failed");

  a_roof_floor_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL] && ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR])
    |=> ch3_ctl_r.core_on == $past(ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE]))
    else $error("roof floor gated enable");

  // Roof/floor mode: a low selected pin asks for the floor voltage
  a_floor_pin_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL] && ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR])
    |=> ch3_ctl_r.floor_select
        == !$past(ch3_enable_and_mode_r[BCRC_BIT_PIN_SELECT] ? enable_pin_b : enable_pin_a))
    else $error("floor select wrong");

  // Outside roof/floor mode the roof voltage always applies
  a_roof_outside_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    !(ch3_enable_and_mode_r[BCRC_BIT_PIN_CONTROL] && ch3_enable_and_mode_r[BCRC_BIT_ROOF_FLOOR])
    |=> !ch3_ctl_r.floor_select)
    else $error("floor select outside mode");

  a_discharge_off: assert property (@(posedge mclk) disable iff (!rst_n)
    ch3_ctl_r.discharge_on |-> !ch3_ctl_r.core_on)
    else $error("discharge while on");

  // A cleared discharge bit keeps the resistor away in every state
  a_discharge_held_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !ch3_enable_and_mode_r[BCRC_BIT_DISCHARGE] |=> !ch3_ctl_r.discharge_on)
    else $error("discharge with bit clear");

  // Core off by its bit and discharge allowed: resistor must connect
  a_discharge_when_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (!ch3_enable_and_mode_r[BCRC_BIT_CORE_ENABLE] && ch3_enable_and_mode_r[BCRC_BIT_DISCHARGE])
    |=> ch3_ctl_r.discharge_on)
    else $error("discharge missing while off");

  a_forced_pwm_map: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 ch3_ctl_r.forced_pwm == $past(ch3_enable_and_mode_r[BCRC_BIT_FORCED_PWM]))
    else $error("forced pwm mismatch");

  a_ilim_live_write: assert property (@(posedge mclk) disable iff (!rst_n)
    s_limit_write
    |=> ##1 ch3_ctl_r.current_limit == $past(wr_req.wdata[BCRC_ILIM_MSB:BCRC_ILIM_LSB], 2))
    else $error("current limit not applied");

  a_slew_live_write: assert property (@(posedge mclk) disable iff (!rst_n)
    s_limit_write
    |=> ##1 ch3_ctl_r.slew_select == $past(wr_req.wdata[BCRC_SLEW_MSB:BCRC_SLEW_LSB], 2))
    else $error("slew not applied");

  a_reserved_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_write
    |=> ch3_enable_and_mode_r == $past(wr_req.wdata))
    else $error("write not stored");

  a_voltage_segment: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch0_output_voltage_r >= BCRC_VSEG2_FIRST) |=> ch0_segment_r == 2'h2)
    else $error("voltage segment wrong");

  // Lowest segment, 10 mV steps
  a_voltage_low_seg: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch0_output_voltage_r < BCRC_VSEG1_FIRST) |=> ch0_segment_r == 2'h0)
    else $error("low voltage segment wrong");

  // Middle segment, 5 mV steps, BCRC_VSEG1_FIRST included, BCRC_VSEG2_FIRST excluded
  a_voltage_mid_seg: assert property (@(posedge mclk) disable iff (!rst_n)
    (ch0_output_voltage_r >= BCRC_VSEG1_FIRST && ch0_output_voltage_r < BCRC_VSEG2_FIRST)
    |=> ch0_segment_r == 2'h1)
    else $error("middle voltage segment wrong");

  // Limit register keeps every written bit, reserved ones too
  a_limit_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    s_limit_write |=> ch3_limit_and_slew_r == $past(wr_req.wdata))
    else $error("limit write not stored");

  // Voltage register reads back one cycle after its address is shown
  a_read_voltage: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_addr == BCRC_ADDR_CH0_OUTPUT_VOLTAGE) |=> rd_data_r == $past(ch0_output_voltage_r))
    else $error("voltage read back wrong");

  // Addresses outside the bank read as zero
  a_read_unmapped: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_addr != BCRC_ADDR_CH3_ENABLE_AND_MODE && rd_addr != BCRC_ADDR_CH3_LIMIT_AND_SLEW
     && rd_addr != BCRC_ADDR_CH0_OUTPUT_VOLTAGE) |=> rd_data_r == BCRC_READ_UNMAPPED)
    else $error("unmapped read not zero");

  // Writes outside the bank leave every register alone
  a_unmapped_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_req.wr_en && wr_req.addr != BCRC_ADDR_CH3_ENABLE_AND_MODE
     && wr_req.addr != BCRC_ADDR_CH3_LIMIT_AND_SLEW && wr_req.addr != BCRC_ADDR_CH0_OUTPUT_VOLTAGE)
    |=> $stable(ch3_enable_and_mode_r) && $stable(ch3_limit_and_slew_r) && $stable(ch0_output_voltage_r))
    else $error("unmapped write changed a register");

endmodule : bcrc_regs

/* File: design/bcrc_pkg.sv */
// Package: register map, field layout, reset values and carriers for the rail control bank
package bcrc_pkg;

  // Register indices on the serial port register address
  localparam logic [7:0] BCRC_ADDR_CH3_ENABLE_AND_MODE = 8'h08;
  localparam logic [7:0] BCRC_ADDR_CH3_LIMIT_AND_SLEW  = 8'h09;
  localparam logic [7:0] BCRC_ADDR_CH0_OUTPUT_VOLTAGE  = 8'h0a;

  // Field positions of the channel 3 enable and mode register
  localparam int BCRC_BIT_CORE_ENABLE  = 7;
  localparam int BCRC_BIT_PIN_CONTROL  = 6;
  localparam int BCRC_BIT_PIN_SELECT   = 5;
  localparam int BCRC_BIT_ROOF_FLOOR   = 4;
  localparam int BCRC_BIT_DISCHARGE    = 3;
  localparam int BCRC_BIT_FORCED_PWM   = 1;

  // Field positions of the channel 3 limit and slew register
  localparam int BCRC_ILIM_MSB  = 5;
  localparam int BCRC_ILIM_LSB  = 3;
  localparam int BCRC_SLEW_MSB  = 2;
  localparam int BCRC_SLEW_LSB  = 0;

  // Reset values
  localparam logic [7:0] BCRC_RST_CH3_ENABLE_AND_MODE = 8'he8;
  localparam logic [7:0] BCRC_RST_CH3_LIMIT_AND_SLEW  = 8'h34;
  localparam logic [7:0] BCRC_RST_CH0_OUTPUT_VOLTAGE  = 8'h37;
  localparam logic [7:0] BCRC_READ_UNMAPPED           = 8'h00;

  // Voltage code segment boundaries
  localparam logic [7:0] BCRC_VSEG1_FIRST = 8'h18;
  localparam logic [7:0] BCRC_VSEG2_FIRST = 8'h9e;

  // Register write request from the serial port
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcrc_wr_t;

  // Decoded channel 3 controls toward the analog core
  typedef struct packed {
    logic       core_on;
    logic       floor_select;
    logic       discharge_on;
    logic       forced_pwm;
    logic [2:0] current_limit;
    logic [2:0] slew_select;
  } bcrc_ch3_ctl_t;

endpackage : bcrc_pkg

/* File: design/bcrc_ch3_decode.sv */
// Combinational enable, roof/floor and discharge decode for channel 3
`timescale 1ns/1ps
module bcrc_ch3_decode
  import bcrc_pkg::*;
(
  input  wire logic [7:0]    enable_mode,
  input  wire logic [7:0]    limit_slew,
  input  wire logic          enable_pin_a,
  input  wire logic          enable_pin_b,
  output bcrc_ch3_ctl_t      ctl
);

  logic pin_level;
  logic pin_gates_enable;
  logic core_on;

  // Pin choice only matters while pin control is on
  assign pin_level        = enable_mode[BCRC_BIT_PIN_SELECT] ? enable_pin_b : enable_pin_a;
  // In roof/floor mode the pin picks the voltage, not the on state
  assign pin_gates_enable = enable_mode[BCRC_BIT_PIN_CONTROL] && !enable_mode[BCRC_BIT_ROOF_FLOOR];

  // Register bit alone, or register bit AND the selected pin
  assign core_on = enable_mode[BCRC_BIT_CORE_ENABLE] && (!pin_gates_enable || pin_level);

  always_comb begin
    ctl               = '0;
    ctl.core_on       = core_on;
    ctl.floor_select  = enable_mode[BCRC_BIT_PIN_CONTROL] && enable_mode[BCRC_BIT_ROOF_FLOOR]
                        && !pin_level;
    ctl.discharge_on  = !core_on && enable_mode[BCRC_BIT_DISCHARGE];
    ctl.forced_pwm    = enable_mode[BCRC_BIT_FORCED_PWM];
    ctl.current_limit = limit_slew[BCRC_ILIM_MSB:BCRC_ILIM_LSB];
    ctl.slew_select   = limit_slew[BCRC_SLEW_MSB:BCRC_SLEW_LSB];
  end

endmodule : bcrc_ch3_decode

/* File: dv/tb.sv */
// Self-checking bench for the rail control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import bcrc_pkg::*;
  logic          mclk, rst_n, pa, pb;
  bcrc_wr_t      wr;
  logic [7:0]    rda, rdd, vcode;
  logic [1:0]    seg;
  bcrc_ch3_ctl_t ctl;
  logic [7:0]    m [3];
  logic [31:0]   lf;
  int            bad_count, comparisons;
  bcrc_regs uut (.mclk(mclk), .rst_n(rst_n), .wr_req(wr), .rd_addr(rda), .rd_data_r(rdd),
    .enable_pin_a(pa), .enable_pin_b(pb), .ch3_ctl_r(ctl), .ch0_voltage_code_r(vcode), .ch0_segment_r(seg));
  // Free-running 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] mread(logic [7:0] a);
    return (a >= 8'h08 && a <= 8'h0a) ? m[a - 8'h08] : BCRC_READ_UNMAPPED;
  endfunction : mread
  // Write held for exactly one rising edge; caller idles the strobe
  task automatic wr8(logic [7:0] a, logic [7:0] d);
    wr = '{1'b1, a, d};
    @(negedge mclk);
    if (a >= 8'h08 && a <= 8'h0a) m[a - 8'h08] = d;
  endtask : wr8
  // Reads every place, one unmapped, then the decoded outputs
  task automatic check();
    logic p;
    logic on;
    wr.wr_en = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rda = 8'h08 + i[7:0];
      @(negedge mclk);
      `CHK(rdd, mread(8'h08 + i[7:0]))
    end
    p = m[0][BCRC_BIT_PIN_SELECT] ? pb : pa;
    on = m[0][7] & (!m[0][6] | m[0][4] | p);
    `CHK(ctl.core_on, on)
    `CHK(ctl.floor_select, m[0][6] & m[0][4] & !p)
    `CHK(ctl.discharge_on, !on & m[0][3])
    `CHK(ctl.forced_pwm, m[0][1])
    `CHK(ctl.current_limit, m[1][5:3])
    `CHK(ctl.slew_select, m[1][2:0])
    `CHK(vcode, m[2])
    `CHK(seg, (m[2] < 8'h18) ? 2'd0 : (m[2] < 8'h9e) ? 2'd1 : 2'd2)
  endtask : check
  // Reset is held six cycles; writes during it must be lost
  task automatic do_reset();
    rst_n = 1'b0;
    wr = '{1'b1, 8'h09, 8'h00};
    repeat (6) @(negedge mclk);
    `CHK(ctl, bcrc_ch3_ctl_t'(0))
    `CHK(vcode, 8'h37)
    rst_n = 1'b1;
    m[0] = 8'he8;
    m[1] = 8'h34;
    m[2] = 8'h37;
    check();
  endtask : do_reset
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // Watchdog well past the expected run length
  initial begin
    #2000000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [7:0] vt [6];
    vt = '{8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff, 8'h00};
    rst_n = 1'b0;
    pa = 1'b0;
    pb = 1'b0;
    rda = 8'h00;
    wr = '0;
    lf = 32'h4ecd3a78;
    bad_count = 0;
    comparisons = 0;
    @(negedge mclk);
    do_reset();
    // Register bit alone, then pin control with both pins and modes
    wr8(8'h08, 8'h80); check();
    wr8(8'h08, 8'h08); check();
    for (int i = 0; i < 32; i++) begin
      pa = i[3];
      pb = i[4];
      wr8(8'h08, {1'b1, i[2:0], 4'h5});
      check();
    end
    // Limit and slew codes rewritten while the core runs
    wr8(8'h08, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr8(8'h09, {2'b11, c[2:0], c[2:0] ^ 3'h5});
      check();
    end
    // Segment edges, written back to back
    for (int i = 0; i < 6; i += 2) begin
      wr8(8'h0a, vt[i]);
      wr8(8'h0a, vt[i + 1]);
      check();
      wr8(8'h0a, vt[i]);
      check();
    end
    // Random traffic, pins and addresses
    for (int i = 0; i < 60; i++) begin
      lf = lfsr(lf);
      pa = lf[8];
      pb = lf[9];
      wr8(lf[1:0] == 2'd3 ? lf[23:16] : 8'h08 + {6'd0, lf[1:0]}, lf[31:24]);
      check();
    end
    do_reset();
    conclude();
  end
endmodule : tb
